// >>> core/ir_remote_pin_ports.sv
// top level: key ports, sense pins, carrier output, reset pin, apb
//
// Summary of operation
// - key-scan port switches direction as one; drives high after reset
// - key-scan pins in input mode get pull-downs
// - key-scan port in output mode drives software scan levels
// - sense pull-downs enabled separately, one bit each of a two-bit setting
// - first sense pin off (high impedance) when input cancelled, and at reset
// - second sense pin: input, or active-low indicator high after reset
// - indicator low for the whole emission, not each carrier cycle, in output mode
// - remote output active high, low during and after reset
// - carrier from fx/8,16,64,96,128,192 or constant high
// - low on reset pin resets; pin has internal pull-up
// - power-on detector reset drives the reset pin low
// - four key-return pull-downs enabled together
// - carrier from two select, disable and halve bits; reset 00000011
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ir_remote_pin_ports (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  key_io_in,
  output logic [7:0]       key_io_out,
  output logic [7:0]       key_io_oe,
  output logic [7:0]       key_io_pd,
  input  wire logic [3:0]  key_ret_in,
  output logic [3:0]       key_ret_pd,
  input  wire logic        sense_a_in,
  output logic             sense_a_pd,
  input  wire logic        sense_b_indicator_in,
  output logic             sense_b_indicator_out,
  output logic             sense_b_indicator_oe,
  output logic             sense_b_indicator_pd,
  output logic             ir_carrier_out,
  input  wire logic        tx_active,
  input  wire logic        reset_pin_in,
  input  wire logic        power_on_detector,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             reset_pin_pu,
  output logic             cpu_rst
);
  import ir_port_pkg::*;

  logic [7:0]  carrier_q;
  logic [7:0]  port_q;
  logic [7:0]  key_out_q;
  logic [2:0]  rst_sync_q;
  logic [2:0]  por_sync_q;
  logic [15:0] sync_in_q [3];
  logic [15:0] pins_q;
  logic [7:0]  por_cnt_q;
  logic        ir_q;
  logic        ind_q;
  logic        carrier;
  logic        wr_en;
  logic        mapped;
  logic [15:0] raw_in;

  // *****************************************
  // reset pin and power-on detector
  // *****************************************
  // pin and detector pass three flops; active level counts when 2nd and 3rd agree
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_sync_q <= 3'h7;
      por_sync_q <= 3'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], reset_pin_in};
      por_sync_q <= {por_sync_q[1:0], power_on_detector};
    end
  end

  // hold the pin low a little past the detector so the pad really falls
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      por_cnt_q <= 8'h00;
    else if (por_sync_q[1] && por_sync_q[2])
      por_cnt_q <= 8'(POR_CYCLES);
    else if (por_cnt_q != 8'h00)
      por_cnt_q <= por_cnt_q - 8'h01;
  end

  assign reset_pin_oe  = (por_cnt_q != 8'h00) || (por_sync_q[1] && por_sync_q[2]);
  assign reset_pin_out = 1'b0;
  assign reset_pin_pu  = 1'b1;
  // pin low seen by both late stages resets the core
  assign cpu_rst = sys_rst || (!rst_sync_q[1] && !rst_sync_q[2]) || reset_pin_oe;

  // *****************************************
  // apb slave
  // *****************************************
  function automatic logic known(input logic [7:0] a);
    known = (a == CARRIER_CTRL_OFFS) || (a == PORT_CTRL_OFFS) ||
            (a == KEY_OUT_OFFS) || (a == PIN_STATUS_OFFS);
  endfunction : known

  assign mapped  = known(paddr);
  assign wr_en   = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk_sys) begin
    if (cpu_rst) begin
      carrier_q <= CARRIER_RST;
      port_q    <= PORT_RST;
      key_out_q <= KEY_OUT_RST;
    end else if (wr_en) begin
      if (paddr == CARRIER_CTRL_OFFS)
        carrier_q <= {4'h0, pwdata[3:0]};
      if (paddr == PORT_CTRL_OFFS)
        port_q <= {1'b0, pwdata[6:0]};
      if (paddr == KEY_OUT_OFFS)
        key_out_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        CARRIER_CTRL_OFFS: prdata <= {24'h0, carrier_q};
        PORT_CTRL_OFFS:    prdata <= {24'h0, port_q};
        KEY_OUT_OFFS:      prdata <= {24'h0, key_out_q};
        PIN_STATUS_OFFS:   prdata <= {16'h0, pins_q};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // *****************************************
  // pin input synchronisers
  // *****************************************
  assign raw_in = {1'b0, ir_q, sense_b_indicator_in, sense_a_in,
                   key_ret_in, key_io_in};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_in_q[0] <= 16'h0000;
      sync_in_q[1] <= 16'h0000;
      sync_in_q[2] <= 16'h0000;
    end else begin
      sync_in_q[0] <= raw_in;
      sync_in_q[1] <= sync_in_q[0];
      sync_in_q[2] <= sync_in_q[1];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_agree
      always_ff @(posedge clk_sys) begin
        if (sys_rst)
          pins_q[gi] <= 1'b0;
        else if (sync_in_q[1][gi] == sync_in_q[2][gi])
          pins_q[gi] <= sync_in_q[2][gi];
      end
    end
  endgenerate

  // *****************************************
  // carrier and output pins
  // *****************************************
  ir_carrier_gen u_carrier (
    .clk_sys     (clk_sys),
    .sys_rst     (cpu_rst),
    .sel         (carrier_q[SEL_LSB +: 2]),
    .carrier_off (carrier_q[CARRIER_OFF]),
    .halve       (carrier_q[HALVE]),
    .carrier     (carrier)
  );

  always_ff @(posedge clk_sys) begin
    if (cpu_rst) begin
      ir_q  <= 1'b0;
      ind_q <= 1'b1;
    end else begin
      ir_q  <= tx_active && carrier;
      // indicator tracks emission, not each carrier cycle
      ind_q <= !(tx_active && port_q[SENSE_B_OUT]) && port_q[IND_LEVEL];
    end
  end
  assign ir_carrier_out = ir_q;

  assign key_io_oe  = {8{port_q[KEY_DIR_OUT]}};
  assign key_io_out = key_out_q;
  assign key_io_pd  = {8{!port_q[KEY_DIR_OUT]}};
  assign key_ret_pd = {4{port_q[RET_PD_EN]}};
  // off state: no pull-down, no drive, pin floats
  assign sense_a_pd = port_q[SENSE_A_IN] && port_q[SENSE_PD_LSB];
  assign sense_b_indicator_oe  = port_q[SENSE_B_OUT];
  assign sense_b_indicator_out = ind_q;
  assign sense_b_indicator_pd  =
    !port_q[SENSE_B_OUT] && port_q[SENSE_PD_LSB + 1];

  // *****************************************
  // assertions
  // *****************************************
  a_ir_low_reset: assert property (@(posedge clk_sys)
    cpu_rst |=> !ir_carrier_out)
    else $error("ir output not low after reset");
  a_ind_follows_tx: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (tx_active && port_q[SENSE_B_OUT]) |=> !sense_b_indicator_out)
    else $error("indicator not low while emitting");
  a_key_dir_group: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (key_io_oe == 8'h00) || (key_io_oe == 8'hFF))
    else $error("key port direction split");
  a_key_pd_input: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    key_io_pd == ~key_io_oe)
    else $error("key pull-down wrong");
  a_key_rst_high: assert property (@(posedge clk_sys)
    sys_rst |=> (key_io_oe == 8'hFF) && (key_io_out == 8'hFF))
    else $error("key port not high after reset");
  a_sense_a_off: assert property (@(posedge clk_sys)
    sys_rst |=> !sense_a_pd)
    else $error("first sense pin not off after reset");
  a_por_drives: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (por_sync_q[1] && por_sync_q[2]) |-> reset_pin_oe && !reset_pin_out)
    else $error("reset pin not driven on power-on");
  a_carrier_rst: assert property (@(posedge clk_sys)
    sys_rst |=> carrier_q == 8'h03)
    else $error("carrier control reset value wrong");
  a_ret_pd_group: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (key_ret_pd == 4'h0) || (key_ret_pd == 4'hF))
    else $error("key return pull-downs split");

  // *****************************************
  // multi-step checks
  // *****************************************
  sequence s_por_active;
    por_sync_q[1] && por_sync_q[2];
  endsequence
  sequence s_por_gone;
    s_por_active ##1 !(por_sync_q[1] && por_sync_q[2]);
  endsequence
  sequence s_pin_low3;
    !reset_pin_in [*3];
  endsequence
  sequence s_emit_start;
    !tx_active ##1 (tx_active && port_q[SENSE_B_OUT]);
  endsequence
  sequence s_emit_stop;
    tx_active ##1 (!tx_active && port_q[IND_LEVEL]);
  endsequence

  // stretch must outlast the detector, or the pad may never reach low
  a_por_stretch: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    s_por_gone |-> reset_pin_oe [*8])
    else $error("reset pin released too soon");

  a_pin_resets: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    s_pin_low3 |=> cpu_rst)
    else $error("low reset pin did not reset core");

  a_emit_lamp: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    s_emit_start |=> !sense_b_indicator_out)
    else $error("indicator not lit at emission start");

  a_stop_lamp: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    s_emit_stop |=> sense_b_indicator_out && !ir_carrier_out)
    else $error("indicator or remote not idle after emission");

  a_wr_key: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (psel && penable && pwrite && paddr == KEY_OUT_OFFS)
    |=> key_io_out == $past(pwdata[7:0]))
    else $error("scan level write lost");

  a_wr_port: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (psel && penable && pwrite && paddr == PORT_CTRL_OFFS)
    |=> port_q == {1'b0, $past(pwdata[6:0])})
    else $error("port control write lost");

  a_wr_carrier: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (psel && penable && pwrite && paddr == CARRIER_CTRL_OFFS)
    |=> carrier_q == {4'h0, $past(pwdata[3:0])})
    else $error("carrier control write lost");

  a_unmapped_kept: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (psel && penable && pwrite && !mapped)
    |=> $stable(port_q) && $stable(carrier_q) && $stable(key_out_q))
    else $error("unmapped write changed a register");

  a_unmapped_err: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (psel && penable && !mapped) |-> pslverr)
    else $error("unmapped access without error");

  a_ir_idle: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    !tx_active |=> !ir_carrier_out)
    else $error("remote output active while idle");

  a_ir_steady: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (tx_active && carrier_q[CARRIER_OFF]) |=> ir_carrier_out)
    else $error("remote output not steady high");

  a_ind_idle: assert property (@(posedge clk_sys)
    disable iff (cpu_rst)
    (!tx_active && port_q[IND_LEVEL]) |=> sense_b_indicator_out)
    else $error("indicator not high while idle");

  // a driven pin with a pull-down would waste current
  a_sense_b_no_pd: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    sense_b_indicator_oe |-> !sense_b_indicator_pd)
    else $error("pull-down on driven sense pin");

  a_sense_a_cancel: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !port_q[SENSE_A_IN] |-> !sense_a_pd)
    else $error("first sense pin not off when cancelled");

  a_ret_pd_off: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    !port_q[RET_PD_EN] |-> key_ret_pd == 4'h0)
    else $error("return pull-downs on while disabled");

  a_regs_on_reset: assert property (@(posedge clk_sys)
    cpu_rst |=> (key_out_q == KEY_OUT_RST) && (port_q == PORT_RST))
    else $error("control bits not reset");

  a_read_key: assert property (@(posedge clk_sys)
    disable iff (sys_rst)
    (psel && !penable && !pwrite && paddr == KEY_OUT_OFFS)
    |=> prdata == {24'h00, $past(key_out_q)})
    else $error("scan level read wrong");
endmodule : ir_remote_pin_ports
`default_nettype wire

// >>> core/ir_port_pkg.sv
// package: register map, field positions, reset values, power-on reset stretch
package ir_port_pkg;
  // apb register byte offsets
  localparam logic [7:0] CARRIER_CTRL_OFFS = 8'h00;
  localparam logic [7:0] PORT_CTRL_OFFS    = 8'h04;
  localparam logic [7:0] KEY_OUT_OFFS      = 8'h08;
  localparam logic [7:0] PIN_STATUS_OFFS   = 8'h0C;
  // carrier control fields
  localparam int        SEL_LSB      = 0;
  localparam int        CARRIER_OFF  = 2;
  localparam int        HALVE        = 3;
  localparam logic [7:0] CARRIER_RST = 8'h03;
  // port control fields
  localparam int        KEY_DIR_OUT  = 0;
  localparam int        SENSE_PD_LSB = 1;
  localparam int        SENSE_A_IN   = 3;
  localparam int        SENSE_B_OUT  = 4;
  localparam int        RET_PD_EN    = 5;
  localparam int        IND_LEVEL    = 6;
  localparam logic [7:0] PORT_RST    = 8'h51;
  localparam logic [7:0] KEY_OUT_RST = 8'hFF;
  // power-on reset stretch
  localparam int        POR_NS       = 1000;
  localparam int        CLK_NS       = 100;
  localparam int        POR_CYCLES   = (POR_NS + CLK_NS - 1) / CLK_NS;
endpackage : ir_port_pkg

// >>> core/ir_carrier_gen.sv
// carrier generator: selectable divider of the system clock
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_gen (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [1:0] sel,
  input  wire logic       carrier_off,
  input  wire logic       halve,
  output logic            carrier
);
  import ir_port_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] period;
  logic [7:0] high_len;
  logic [7:0] base_p;
  logic [7:0] base_h;

  // *****************************************
  // period table
  // *****************************************
  always_comb begin
    case (sel)
      2'h0: begin base_p = 8'h08; base_h = 8'h04; end
      2'h1: begin base_p = 8'h40; base_h = 8'h20; end
      2'h2: begin base_p = 8'h60; base_h = 8'h30; end
      default: begin base_p = 8'h60; base_h = 8'h20; end
    endcase
    period   = halve ? {base_p[6:0], 1'b0} : base_p;
    high_len = halve ? {base_h[6:0], 1'b0} : base_h;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || carrier_off || cnt_q >= period - 8'h01)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end

  // constant high when carrier is disabled
  assign carrier = carrier_off ? 1'b1 : (cnt_q < high_len);
endmodule : ir_carrier_gen
`default_nettype wire

// >>> dv/ir_key_model.sv
// partner model: key matrix, indicator lamp and reset switch
`timescale 1ns/1ps
`default_nettype none
module ir_key_model (
  input  wire logic       clk_sys,
  input  wire logic       hold_rst_n,
  input  wire logic       press,
  input  wire logic [7:0] key_io_out,
  input  wire logic [7:0] key_io_oe,
  input  wire logic [7:0] key_io_pd,
  input  wire logic [3:0] key_ret_pd,
  input  wire logic       sense_b_indicator_out,
  input  wire logic       sense_b_indicator_oe,
  input  wire logic       sense_b_indicator_pd,
  input  wire logic       reset_pin_out,
  input  wire logic       reset_pin_oe,
  input  wire logic       reset_pin_pu,
  output logic [7:0]      key_io_in,
  output logic [3:0]      key_ret_in,
  output logic            sense_a_in,
  output logic            sense_b_indicator_in,
  output logic            reset_pin_in
);
  // ******************
  // pin levels
  // ******************
  logic flip_q = 1'b0;
  // a floating line wanders, so a stale level is never trusted
  always @(posedge clk_sys) flip_q <= ~flip_q;
  assign key_io_in = (key_io_oe & key_io_out)
                   | (~key_io_oe & ~key_io_pd & {8{flip_q}});
  // key joins scan 0 to return 0; returns 3..1 held low
  assign key_ret_in = {3'b000, press ? key_io_in[0]
                               : (~key_ret_pd[0] & flip_q)};
  assign sense_a_in = 1'b0;
  assign sense_b_indicator_in = sense_b_indicator_oe ? sense_b_indicator_out
                              : (~sense_b_indicator_pd & flip_q);
  assign reset_pin_in = reset_pin_oe ? reset_pin_out
                      : (hold_rst_n & (reset_pin_pu | flip_q));
endmodule : ir_key_model
`default_nettype wire

// >>> dv/test_ir_remote_pin_ports.sv
// testbench: apb-driven checks of key, sense, carrier and reset pins
`timescale 1ns/1ps
`default_nettype none
module test_ir_remote_pin_ports;
  import ir_port_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite, tx_active;
  logic        power_on_detector, hold_rst_n, press, err;
  logic [7:0]  paddr, key_io_in, key_io_out, key_io_oe, key_io_pd;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, sense_a_in, sense_a_pd, ir_carrier_out;
  logic [3:0]  key_ret_in, key_ret_pd;
  logic        sense_b_indicator_in, sense_b_indicator_out;
  logic        sense_b_indicator_oe, sense_b_indicator_pd, cpu_rst;
  logic        reset_pin_in, reset_pin_out, reset_pin_oe, reset_pin_pu;
  int          mismatches, n_compared;
  // ******************
  // structure and tasks
  // ******************
  ir_remote_pin_ports DUT (.clk_sys, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .key_io_in, .key_io_out,
    .key_io_oe, .key_io_pd, .key_ret_in, .key_ret_pd, .sense_a_in,
    .sense_a_pd, .sense_b_indicator_in, .sense_b_indicator_out,
    .sense_b_indicator_oe, .sense_b_indicator_pd, .ir_carrier_out,
    .tx_active, .reset_pin_in, .power_on_detector, .reset_pin_out,
    .reset_pin_oe, .reset_pin_pu, .cpu_rst);
  ir_key_model far_side (.clk_sys, .hold_rst_n, .press, .key_io_out,
    .key_io_oe, .key_io_pd, .key_ret_pd, .sense_b_indicator_out,
    .sense_b_indicator_oe, .sense_b_indicator_pd, .reset_pin_out,
    .reset_pin_oe, .reset_pin_pu, .key_io_in, .key_ret_in, .sense_a_in,
    .sense_b_indicator_in, .reset_pin_in);
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      mismatches++;
      results();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset;
    @(negedge clk_sys);
    chk({key_io_oe, key_io_out}, 16'hFFFF, "scan");
    chk({sense_b_indicator_oe, sense_b_indicator_out}, 2'b11, "lamp");
    chk({sense_a_pd, reset_pin_pu}, 2'b01, "sense a, pullup");
    apb(1'b0, CARRIER_CTRL_OFFS, 0);
    chk(rd, 32'(CARRIER_RST), "carrier reg");
    apb(1'b0, PORT_CTRL_OFFS, 0);
    chk(rd, 32'(PORT_RST), "port reg");
    $display("reset done");
  endtask : t_reset
  task automatic t_keys;
    apb(1'b1, PORT_CTRL_OFFS, 32'h0000_0050);
    @(negedge clk_sys);
    chk({key_io_oe, key_io_pd}, 16'h00FF, "scan input");
    apb(1'b1, PORT_CTRL_OFFS, 32'(PORT_RST));
    apb(1'b1, KEY_OUT_OFFS, 32'h0000_00A5);
    press <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({key_io_pd, key_io_out}, 16'h00A5, "scan out");
    apb(1'b0, PIN_STATUS_OFFS, 0);
    chk(rd[11:0], 12'h1A5, "key matrix");
    press <= 1'b0;
    $display("keys done");
  endtask : t_keys
  task automatic t_pulls;
    apb(1'b1, PORT_CTRL_OFFS, 32'h0000_002F);
    @(negedge clk_sys);
    chk({sense_a_pd, sense_b_indicator_pd}, 2'b11, "sense pulls");
    chk(sense_b_indicator_oe, 1'b0, "sense b input");
    chk(key_ret_pd, 4'hF, "return pulls");
    apb(1'b1, PORT_CTRL_OFFS, 32'h0000_0001);
    @(negedge clk_sys);
    chk({sense_a_pd, sense_b_indicator_pd, key_ret_pd}, 0, "off");
    apb(1'b1, PORT_CTRL_OFFS, 32'(PORT_RST));
    $display("pulls done");
  endtask : t_pulls
  task automatic t_carrier;
    int   per [8] = '{8, 64, 96, 96, 16, 128, 192, 192};
    int   p;
    int   k;
    logic last;
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, CARRIER_CTRL_OFFS, 32'({s[2], 1'b0, s[1:0]}));
      tx_active <= 1'b1;
      p = 0;
      k = 0;
      last = 1'b1;
      // period is counted between two rising edges, bounded
      for (int n = 0; n < 1000 && k < 2; n++) begin
        @(negedge clk_sys);
        if (k == 1) p++;
        if (ir_carrier_out && !last) k++;
        last = ir_carrier_out;
      end
      chk(p, per[s], "carrier period");
      chk(sense_b_indicator_out, 1'b0, "lamp on");
    end
    apb(1'b1, CARRIER_CTRL_OFFS, 32'h0000_0004);
    repeat (3) @(negedge clk_sys);
    chk(ir_carrier_out, 1'b1, "no carrier");
    repeat (200) @(negedge clk_sys);
    chk(ir_carrier_out, 1'b1, "no carrier held");
    @(posedge clk_sys);
    tx_active <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({ir_carrier_out, sense_b_indicator_out}, 2'b01, "stop");
    apb(1'b1, 8'h10, 32'h0000_00FF);
    chk(err, 1'b1, "unmapped write");
    $display("carrier done");
  endtask : t_carrier
  task automatic t_rst_pin;
    apb(1'b1, KEY_OUT_OFFS, 0);
    power_on_detector <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({reset_pin_oe, reset_pin_out, cpu_rst}, 3'b101, "por");
    chk(ir_carrier_out, 1'b0, "remote in reset");
    @(posedge clk_sys);
    power_on_detector <= 1'b0;
    repeat (POR_CYCLES + 8) @(negedge clk_sys);
    chk({reset_pin_oe, cpu_rst}, 2'b00, "por end");
    apb(1'b0, KEY_OUT_OFFS, 0);
    chk(rd, 32'(KEY_OUT_RST), "por clears");
    hold_rst_n <= 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(cpu_rst, 1'b1, "pin reset");
    @(posedge clk_sys);
    hold_rst_n <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(cpu_rst, 1'b0, "pin released");
    $display("reset pin done");
  endtask : t_rst_pin
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    {sys_rst, hold_rst_n, paddr, pwdata} = {2'b11, 40'h0};
    {psel, penable, pwrite, tx_active, power_on_detector, press} = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(negedge clk_sys);
    chk(ir_carrier_out, 1'b0, "remote in reset");
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_keys();
    t_pulls();
    t_carrier();
    t_rst_pin();
    results();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    results();
  end
endmodule : test_ir_remote_pin_ports
`default_nettype wire
